// [design/occs_map.vh]
`ifndef OCCS_MAP_VH
`define OCCS_MAP_VH

// register offsets (byte-wide registers on an 8-bit port)
`define OCCS_PROC_CLK_CTRL_OFS   8'h00
`define OCCS_MAIN_CLK_MODE_OFS   8'h01
`define OCCS_INT_OSC_CTRL_OFS    8'h02
`define OCCS_CLK_MODE_SEL_OFS    8'h03
`define OCCS_OSC_SETTLE_OFS      8'h04

// proc_clk_ctrl_reg fields
`define OCCS_CPU_DIV_LSB         0
`define OCCS_CPU_DIV_MSB         2
`define OCCS_CPU_SRC_SELECT_BIT  4
`define OCCS_CPU_ON_SUB_BIT      5

// main_clk_mode_reg fields
`define OCCS_MAIN_SRC_SEL_BIT    0
`define OCCS_MAIN_ON_XTAL_BIT    1
`define OCCS_PERIPH_XTAL_BIT     2

// int_osc_ctrl_reg fields
`define OCCS_HS_OSC_STOP_BIT     0
`define OCCS_LS_OSC_STOP_BIT     1

// clk_mode_sel_reg fields
`define OCCS_SUB_OSC_SEL_BIT     4
`define OCCS_MAIN_XTAL_EN_BIT    6
`define OCCS_EXT_CLK_SEL_BIT     7

// osc_settle_select field width
`define OCCS_SETTLE_W            3

// reset values
`define OCCS_CPU_DIV_RST         3'h1
`define OCCS_SETTLE_RST          3'h5

// divider codes: 000..100 legal, others prohibited
`define OCCS_CPU_DIV_MAX         3'h4
`define OCCS_SUB_DIV_EXP         3'h1

// cpu clock source codes
`define OCCS_SRC_HS              2'h0
`define OCCS_SRC_MAIN            2'h1
`define OCCS_SRC_SUB             2'h2

// clock switch gap: time in ns and cycles at 100 MHz (least time, rounded up)
`define OCCS_CLK_PERIOD_NS       10
`define OCCS_SW_GAP_NS           30
`define OCCS_SW_GAP_CYC          ((`OCCS_SW_GAP_NS + `OCCS_CLK_PERIOD_NS - 1) / `OCCS_CLK_PERIOD_NS)

`endif

// [design/occs_clk_switch.v]
`timescale 1ns/1ns
`include "occs_map.vh"

module occs_clk_switch #(
    parameter N   = 3,
    parameter SW  = 2,
    parameter GAP = `OCCS_SW_GAP_CYC
) (
    input  wire          clk,
    input  wire          rst_b,
    input  wire [SW-1:0] sel_req,
    input  wire [N-1:0]  ticks,
    output reg  [SW-1:0] sel_cur_q,
    output reg           tick_q,
    output reg           busy_q
);
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_GATE = 3'b010;
    localparam [2:0] ST_SWAP = 3'b100;

    reg [2:0] state_q;
    reg [7:0] gap_q;

    // gate the output, hold it quiet, then swap the source
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q   <= ST_IDLE;
            gap_q     <= 8'h00;
            sel_cur_q <= {SW{1'b0}};
            busy_q    <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (sel_req != sel_cur_q) begin
                        state_q <= ST_GATE;
                        busy_q  <= 1'b1;
                        gap_q   <= GAP[7:0];
                    end
                end
                ST_GATE: begin
                    if (gap_q <= 8'h01) begin
                        state_q <= ST_SWAP;
                    end else begin
                        gap_q <= gap_q - 8'h01;
                    end
                end
                ST_SWAP: begin
                    sel_cur_q <= sel_req;
                    busy_q    <= 1'b0;
                    state_q   <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                    busy_q  <= 1'b0;
                end
            endcase
        end
    end

    // pass the current source only while no switch runs
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= ticks[sel_cur_q] & ~busy_q & (state_q == ST_IDLE);
        end
    end
endmodule // occs_clk_switch

// [design/occs_clk_div.v]
`timescale 1ns/1ns
`include "occs_map.vh"

module occs_clk_div (
    input  wire       clk,
    input  wire       rst_b,
    input  wire       tick,
    input  wire [2:0] div_exp,
    input  wire       clear,
    output reg        tick_q
);
    reg  [3:0] cnt_q;
    wire [3:0] last;

    assign last = (4'h1 << div_exp) - 4'h1;

    // emit one pulse every 2^div_exp source pulses
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q  <= 4'h0;
            tick_q <= 1'b0;
        end else if (clear) begin
            cnt_q  <= 4'h0;
            tick_q <= 1'b0;
        end else if (tick) begin
            tick_q <= (cnt_q >= last);
            cnt_q  <= (cnt_q >= last) ? 4'h0 : cnt_q + 4'h1;
        end else begin
            tick_q <= 1'b0;
        end
    end
endmodule // occs_clk_div

// [design/occs_top.v]
`timescale 1ns/1ns
`include "occs_map.vh"

// Functional notes
// RL1: writing one to hs_osc_stop_bit halts the internal high-speed clock
// RL2: stop mode also halts the internal high-speed clock
// RL3: cpu_on_sub_flag and main_on_xtal_flag encode the cpu clock source
// RL4: software checks flags and halts peripherals before stopping high-speed clock
// RL5: software sets settle selection before stop when cpu runs on crystal
// RL6: software halts peripherals that cannot run in stop mode first
// RL7: after reset the subsystem crystal pins are plain input port pins
// RL8: sub_osc_select one moves those pins into crystal oscillation mode
// RL9: software times subsystem oscillator settling itself with a timer
// RL10: software leaves sub_osc_select alone while subsystem clock runs
// RL11: cpu_src_select one gives subsystem clock over two; codes above 100 refused
// RL12: clearing sub_osc_select stops subsystem crystal oscillation
// RL13: software confirms cpu_on_sub_flag zero before clearing sub_osc_select
// RL14: stop mode does not halt the subsystem oscillator
// RL15: low-speed clock never feeds cpu; only watchdog, timer and display
// RL16: an option input chooses whether low-speed oscillator may be stopped
// RL17: when unstoppable, writes to ls_osc_stop_bit do not affect it
// RL18: low-speed oscillator runs after reset and clocks the enabled watchdog
// RL19: writing one to ls_osc_stop_bit halts the low-speed clock
// RL20: periph_xtal_select bit 2, main_src_select bit 0, cpu_src_select bit 4
// RL21: clock selection table for cpu and peripherals per the select bits
// RL22: clearing ls_osc_stop_bit restarts the low-speed clock
// RL23: ext_clk_select, main xtal enable, sub_osc_select at bits 7, 6, 4
// RL24: source switches never produce truncated clock pulses
// RL25: status flags show the clock actually driving the cpu
module occs_top (
    input  wire       clk,
    input  wire       rst_b,
    input  wire [7:0] addr,
    input  wire [7:0] wr_data,
    input  wire       wr_stb,
    input  wire       rd_stb,
    output reg  [7:0] rd_data_q,
    input  wire       stop_mode,
    input  wire       ls_osc_stoppable,
    input  wire       wdt_enable,
    input  wire       hs_tick,
    input  wire       x1_tick,
    input  wire       ext_tick,
    input  wire       sub_tick,
    input  wire       low_speed_clk,
    output reg        hs_osc_en_q,
    output reg        main_xtal_en_q,
    output reg        ext_clk_en_q,
    output reg        sub_osc_en_q,
    output reg        sub_pins_osc_mode_q,
    output reg        ls_osc_en_q,
    output reg        cpu_tick_q,
    output reg        periph_tick_q,
    output reg        wdt_tick_q,
    output reg        tmr_ls_tick_q,
    output reg  [2:0] settle_sel_q
);
    // software-written control bits
    reg [2:0] cpu_div_q;
    reg       cpu_src_select_q;
    reg       main_src_select_q;
    reg       periph_xtal_select_q;
    reg       hs_osc_stop_bit_q;
    reg       ls_osc_stop_bit_q;
    reg       sub_osc_select_q;
    reg       main_xtal_bit_q;
    reg       ext_clk_select_q;

    // decoded strobes
    wire wr_pcc;
    wire wr_mcm;
    wire wr_rcm;
    wire wr_osc;
    wire wr_ost;

    assign wr_pcc = wr_stb & (addr == `OCCS_PROC_CLK_CTRL_OFS);
    assign wr_mcm = wr_stb & (addr == `OCCS_MAIN_CLK_MODE_OFS);
    assign wr_rcm = wr_stb & (addr == `OCCS_INT_OSC_CTRL_OFS);
    assign wr_osc = wr_stb & (addr == `OCCS_CLK_MODE_SEL_OFS);
    assign wr_ost = wr_stb & (addr == `OCCS_OSC_SETTLE_OFS);

    // source requests and switch results
    wire       main_tick;
    wire       main_busy;
    reg  [1:0] cpu_req;
    wire       periph_req;
    wire [1:0] cpu_cur;
    wire       periph_cur;
    wire       cpu_sw_tick;
    wire       periph_sw_tick;
    wire       cpu_busy;
    wire       periph_busy;
    wire [2:0] cpu_exp;
    wire       cpu_div_tick;
    wire       cpu_on_sub_flag;
    wire       main_on_xtal_flag;
    wire [2:0] new_div;

    assign new_div = wr_data[`OCCS_CPU_DIV_MSB:`OCCS_CPU_DIV_LSB];

    // processor clock control register
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cpu_div_q        <= `OCCS_CPU_DIV_RST;
            cpu_src_select_q <= 1'b0;
        end else if (wr_pcc) begin
            cpu_src_select_q <= wr_data[`OCCS_CPU_SRC_SELECT_BIT]; // [RL20]
            if (new_div <= `OCCS_CPU_DIV_MAX) begin
                cpu_div_q <= new_div; // prohibited codes refused [RL11]
            end
        end
    end

    // main clock mode register
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            main_src_select_q    <= 1'b0;
            periph_xtal_select_q <= 1'b0;
        end else if (wr_mcm) begin
            main_src_select_q    <= wr_data[`OCCS_MAIN_SRC_SEL_BIT]; // [RL20]
            periph_xtal_select_q <= wr_data[`OCCS_PERIPH_XTAL_BIT]; // [RL20]
        end
    end

    // internal oscillator control register
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hs_osc_stop_bit_q <= 1'b0;
            ls_osc_stop_bit_q <= 1'b0; // low-speed runs after reset [RL18]
        end else if (wr_rcm) begin
            hs_osc_stop_bit_q <= wr_data[`OCCS_HS_OSC_STOP_BIT];
            ls_osc_stop_bit_q <= wr_data[`OCCS_LS_OSC_STOP_BIT];
        end
    end

    // clock operation mode select register
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sub_osc_select_q <= 1'b0; // pins start in port mode [RL7]
            main_xtal_bit_q  <= 1'b0;
            ext_clk_select_q <= 1'b0;
        end else if (wr_osc) begin
            sub_osc_select_q <= wr_data[`OCCS_SUB_OSC_SEL_BIT]; // [RL23]
            main_xtal_bit_q  <= wr_data[`OCCS_MAIN_XTAL_EN_BIT]; // [RL23]
            ext_clk_select_q <= wr_data[`OCCS_EXT_CLK_SEL_BIT]; // [RL23]
        end
    end

    // settle time selection, used by the standby release logic outside
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            settle_sel_q <= `OCCS_SETTLE_RST;
        end else if (wr_ost) begin
            settle_sel_q <= wr_data[`OCCS_SETTLE_W-1:0]; // [RL5]
        end
    end

    // high-speed and main oscillator enables; stop mode halts all three
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hs_osc_en_q    <= 1'b1;
            main_xtal_en_q <= 1'b0;
            ext_clk_en_q   <= 1'b0;
        end else begin
            hs_osc_en_q    <= ~hs_osc_stop_bit_q & ~stop_mode; // [RL1] [RL2]
            main_xtal_en_q <= main_xtal_bit_q & ~ext_clk_select_q & ~stop_mode;
            ext_clk_en_q   <= main_xtal_bit_q & ext_clk_select_q & ~stop_mode;
        end
    end

    // subsystem and low-speed enables; stop mode has no say over these
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sub_osc_en_q        <= 1'b0;
            sub_pins_osc_mode_q <= 1'b0; // [RL7]
            ls_osc_en_q         <= 1'b1; // [RL18]
        end else begin
            sub_osc_en_q        <= sub_osc_select_q; // [RL12] [RL14]
            sub_pins_osc_mode_q <= sub_osc_select_q; // [RL8]
            // the stop bit only counts when the option allows stopping
            ls_osc_en_q <= ~(ls_osc_stop_bit_q & ls_osc_stoppable); // [RL16] [RL17] [RL19] [RL22]
        end
    end

    // crystal or external input as main system clock, with a quiet gap per swap
    occs_clk_switch #(
        .N   (2),
        .SW  (1),
        .GAP (`OCCS_SW_GAP_CYC)
    ) u_main_sw (
        .clk       (clk),
        .rst_b     (rst_b),
        .sel_req   (ext_clk_select_q),
        .ticks     ({ext_tick, x1_tick}),
        .sel_cur_q (),
        .tick_q    (main_tick),
        .busy_q    (main_busy)
    ); // [RL21] [RL24]

    // peripheral source request
    assign periph_req = periph_xtal_select_q; // [RL21]

    always @* begin
        if (cpu_src_select_q) begin
            cpu_req = `OCCS_SRC_SUB; // [RL21]
        end else if (periph_xtal_select_q & main_src_select_q) begin
            cpu_req = `OCCS_SRC_MAIN; // [RL21]
        end else begin
            cpu_req = `OCCS_SRC_HS; // [RL21]
        end
    end

    // cpu clock switch; the low-speed clock is not among its inputs [RL15]
    occs_clk_switch #(
        .N   (3),
        .SW  (2),
        .GAP (`OCCS_SW_GAP_CYC)
    ) u_cpu_sw (
        .clk       (clk),
        .rst_b     (rst_b),
        .sel_req   (cpu_req),
        .ticks     ({sub_tick, main_tick, hs_tick}),
        .sel_cur_q (cpu_cur),
        .tick_q    (cpu_sw_tick),
        .busy_q    (cpu_busy)
    ); // [RL24]

    // peripheral clock switch
    occs_clk_switch #(
        .N   (2),
        .SW  (1),
        .GAP (`OCCS_SW_GAP_CYC)
    ) u_per_sw (
        .clk       (clk),
        .rst_b     (rst_b),
        .sel_req   (periph_req),
        .ticks     ({main_tick, hs_tick}),
        .sel_cur_q (periph_cur),
        .tick_q    (periph_sw_tick),
        .busy_q    (periph_busy)
    ); // [RL24]

    // subsystem source is always halved, whatever the legal code [RL11]
    assign cpu_exp = (cpu_cur == `OCCS_SRC_SUB) ? `OCCS_SUB_DIV_EXP : cpu_div_q;

    // divider restarts on every switch so no short pulse leaks out
    occs_clk_div u_cpu_div (
        .clk     (clk),
        .rst_b   (rst_b),
        .tick    (cpu_sw_tick),
        .div_exp (cpu_exp),
        .clear   (cpu_busy | (main_busy & main_on_xtal_flag)),
        .tick_q  (cpu_div_tick)
    ); // [RL24]

    // status flags follow the switched source, not the request
    assign cpu_on_sub_flag   = (cpu_cur == `OCCS_SRC_SUB); // [RL3] [RL25]
    assign main_on_xtal_flag = (cpu_cur == `OCCS_SRC_MAIN); // [RL3] [RL25]

    // clock outputs; low-speed clock feeds watchdog and timer only
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cpu_tick_q    <= 1'b0;
            periph_tick_q <= 1'b0;
            wdt_tick_q    <= 1'b0;
            tmr_ls_tick_q <= 1'b0;
        end else begin
            cpu_tick_q    <= cpu_div_tick;
            periph_tick_q <= periph_sw_tick & ~periph_busy;
            wdt_tick_q    <= low_speed_clk & ls_osc_en_q & wdt_enable; // [RL15] [RL18]
            tmr_ls_tick_q <= low_speed_clk & ls_osc_en_q; // [RL15]
        end
    end

    // read data, one cycle after the strobe; unmapped reads return zero
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data_q <= 8'h00;
        end else if (rd_stb) begin
            case (addr)
                `OCCS_PROC_CLK_CTRL_OFS:
                    rd_data_q <= {2'h0, cpu_on_sub_flag, cpu_src_select_q,
                                  1'b0, cpu_div_q}; // [RL3]
                `OCCS_MAIN_CLK_MODE_OFS:
                    rd_data_q <= {5'h00, periph_xtal_select_q, main_on_xtal_flag,
                                  main_src_select_q}; // [RL3]
                `OCCS_INT_OSC_CTRL_OFS:
                    rd_data_q <= {6'h00, ls_osc_stop_bit_q, hs_osc_stop_bit_q};
                `OCCS_CLK_MODE_SEL_OFS:
                    rd_data_q <= {ext_clk_select_q, main_xtal_bit_q, 1'b0,
                                  sub_osc_select_q, 4'h0};
                `OCCS_OSC_SETTLE_OFS:
                    rd_data_q <= {5'h00, settle_sel_q};
                default:
                    rd_data_q <= 8'h00;
            endcase
        end else begin
            rd_data_q <= 8'h00;
        end
    end
endmodule // occs_top

// [testbench/occs_properties.sv]
`timescale 1ns/1ns
// watches enable, pin mode, tick and read timing at the block ports
module occs_props (
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic       wr_stb,
    input wire logic       rd_stb,
    input wire logic [7:0] rd_data_q,
    input wire logic       stop_mode,
    input wire logic       ls_osc_stoppable,
    input wire logic       wdt_enable,
    input wire logic       low_speed_clk,
    input wire logic       hs_osc_en_q,
    input wire logic       sub_osc_en_q,
    input wire logic       sub_pins_osc_mode_q,
    input wire logic       ls_osc_en_q,
    input wire logic       wdt_tick_q,
    input wire logic [2:0] settle_sel_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    // stop bit reaches the high-speed enable two edges after the write
    a_hs_stop_bit:
        assert property ((wr_stb && addr == 8'h02 && !stop_mode) ##1 !stop_mode [*2]
            |-> hs_osc_en_q == !$past(wr_data[0], 2)) else $error("hs enable wrong");
    // stop mode held three cycles leaves the high-speed clock off
    a_stop_hs_off:
        assert property (stop_mode [*3] |-> !hs_osc_en_q) else $error("hs runs in stop");
    // crystal pins come out of reset as input port pins
    a_pins_reset:
        assert property ($rose(rst_b) |-> !sub_pins_osc_mode_q) else $error("pins not port");
    // select bit drives both the oscillator and the pin mode
    a_sub_sel_write:
        assert property (wr_stb && addr == 8'h03 |-> ##2
            sub_osc_en_q == $past(wr_data[4], 2) && sub_pins_osc_mode_q == $past(wr_data[4], 2))
            else $error("sub select wrong");
    // stop mode never halts the subsystem oscillator
    a_sub_in_stop:
        assert property (stop_mode && sub_osc_en_q && !wr_stb && !$past(wr_stb)
            |=> sub_osc_en_q) else $error("sub stopped in stop");
    // unstoppable option keeps the low-speed oscillator running
    a_ls_locked:
        assert property (!ls_osc_stoppable [*3] |-> ls_osc_en_q) else $error("ls stopped");
    // stop bit halts or restarts the low-speed oscillator
    a_ls_stop_bit:
        assert property ((wr_stb && addr == 8'h02 && ls_osc_stoppable) ##1 ls_osc_stoppable [*2]
            |-> ls_osc_en_q == !$past(wr_data[1], 2)) else $error("ls enable wrong");
    // watchdog ticks only from a running low-speed clock with watchdog on
    a_wdt_tick_src:
        assert property (wdt_tick_q |-> $past(low_speed_clk && wdt_enable && ls_osc_en_q))
            else $error("stray wdt tick");
    // read data stands one cycle only
    a_rd_idle:
        assert property (!$past(rd_stb) |-> rd_data_q == 8'h00) else $error("read data stuck");
    // settle register reads back what the output carries
    a_settle_read:
        assert property (rd_stb && addr == 8'h04 && !$past(wr_stb)
            |=> rd_data_q == {5'h00, settle_sel_q}) else $error("settle read wrong");
endmodule // occs_props

bind occs_top occs_props u_props (.clk(clk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data_q(rd_data_q), .stop_mode(stop_mode),
    .ls_osc_stoppable(ls_osc_stoppable), .wdt_enable(wdt_enable),
    .low_speed_clk(low_speed_clk), .hs_osc_en_q(hs_osc_en_q), .sub_osc_en_q(sub_osc_en_q),
    .sub_pins_osc_mode_q(sub_pins_osc_mode_q), .ls_osc_en_q(ls_osc_en_q),
    .wdt_tick_q(wdt_tick_q), .settle_sel_q(settle_sel_q));

// [testbench/occs_osc_model.sv]
`timescale 1ns/1ns
// oscillator bank: each source ticks at its own period while enabled
module occs_osc_model #(
    parameter HS_P  = 2,
    parameter X1_P  = 3,
    parameter EXT_P = 4,
    parameter SUB_P = 5,
    parameter LS_P  = 7
) (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic hs_en,
    input  wire logic x1_en,
    input  wire logic ext_en,
    input  wire logic sub_en,
    input  wire logic ls_en,
    output logic      hs_tick,
    output logic      x1_tick,
    output logic      ext_tick,
    output logic      sub_tick,
    output logic      low_speed_clk
);
    int cnt_q;

    // free-running phase counter, ticks launched just after the edge
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q         <= 0;
            hs_tick       <= 1'b0;
            x1_tick       <= 1'b0;
            ext_tick      <= 1'b0;
            sub_tick      <= 1'b0;
            low_speed_clk <= 1'b0;
        end else begin
            cnt_q         <= cnt_q + 1;
            hs_tick       <= hs_en && (cnt_q % HS_P == 0);
            x1_tick       <= x1_en && (cnt_q % X1_P == 0);
            ext_tick      <= ext_en && (cnt_q % EXT_P == 0);
            sub_tick      <= sub_en && (cnt_q % SUB_P == 0);
            low_speed_clk <= ls_en && (cnt_q % LS_P == 0);
        end
    end
endmodule // occs_osc_model

// [testbench/testbench.sv]
`timescale 1ns/1ns
// register walk and tick-rate checks on the clock control block
module testbench;
    logic       clk, rst_b, wr_stb, rd_stb, stop_mode, ls_osc_stoppable, wdt_enable;
    logic [7:0] addr, wr_data, rd_data_q;
    logic [2:0] settle_sel_q;
    logic       hs_tick, x1_tick, ext_tick, sub_tick, low_speed_clk, tmr_ls_tick_q;
    logic       hs_osc_en_q, main_xtal_en_q, ext_clk_en_q, sub_osc_en_q;
    logic       sub_pins_osc_mode_q, ls_osc_en_q, cpu_tick_q, periph_tick_q, wdt_tick_q;
    int         failures, n_tests, k;

    occs_top dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rd_data_q(rd_data_q), .stop_mode(stop_mode),
        .ls_osc_stoppable(ls_osc_stoppable), .wdt_enable(wdt_enable), .hs_tick(hs_tick),
        .x1_tick(x1_tick), .ext_tick(ext_tick), .sub_tick(sub_tick),
        .low_speed_clk(low_speed_clk), .hs_osc_en_q(hs_osc_en_q),
        .main_xtal_en_q(main_xtal_en_q), .ext_clk_en_q(ext_clk_en_q),
        .sub_osc_en_q(sub_osc_en_q), .sub_pins_osc_mode_q(sub_pins_osc_mode_q),
        .ls_osc_en_q(ls_osc_en_q), .cpu_tick_q(cpu_tick_q), .periph_tick_q(periph_tick_q),
        .wdt_tick_q(wdt_tick_q), .tmr_ls_tick_q(tmr_ls_tick_q), .settle_sel_q(settle_sel_q));

    occs_osc_model osc (.clk(clk), .rst_b(rst_b), .hs_en(hs_osc_en_q), .x1_en(main_xtal_en_q),
        .ext_en(ext_clk_en_q), .sub_en(sub_osc_en_q), .ls_en(ls_osc_en_q), .hs_tick(hs_tick),
        .x1_tick(x1_tick), .ext_tick(ext_tick), .sub_tick(sub_tick),
        .low_speed_clk(low_speed_clk));

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic results;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", nm, exp, got);
            failures++;
        end
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr    <= a;
        wr_data <= d;
        wr_stb  <= 1'b1;
        @(posedge clk);
        wr_stb  <= 1'b0;
    endtask

    // one-cycle read strobe, data taken in the cycle after
    task automatic rdv(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        d = rd_data_q;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rdv(a, d);
        chk($sformatf("register %h", a), exp, d);
    endtask

    // wait for a status flag, bounded
    task automatic poll(input logic [7:0] a, input int b, input logic want);
        logic [7:0] d;
        int         i;
        for (i = 0; i < 40; i++) begin
            rdv(a, d);
            if (d[b] === want)
                break;
        end
        if (i == 40) begin
            $display("BAD switch flag expected %h seen %h", want, d[b]);
            failures++;
            results();
        end
    endtask

    task automatic settle;
        repeat (3) @(negedge clk);
    endtask

    // count ticks of cpu (0), peripheral (1), watchdog (2) or timer (3) over 200 cycles
    task automatic rate(input string nm, input int sel, input int lo, input int hi);
        int c;
        c = 0;
        repeat (200) begin
            @(negedge clk);
            c += (sel == 0) ? (cpu_tick_q === 1'b1) :
                 (sel == 1) ? (periph_tick_q === 1'b1) :
                 (sel == 2) ? (wdt_tick_q === 1'b1) : (tmr_ls_tick_q === 1'b1);
        end
        n_tests++;
        if (c < lo || c > hi) begin
            $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, c);
            failures++;
        end
    endtask

    // main sequence
    initial begin
        {addr, wr_data, wr_stb, rd_stb, stop_mode, ls_osc_stoppable} = '0;
        wdt_enable = 1'b1;
        failures   = 0;
        n_tests    = 0;
        rst_b      = 1'b0;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        rd(8'h00, 8'h01);
        rd(8'h01, 8'h00);
        rd(8'h02, 8'h00);
        rd(8'h03, 8'h00);
        rd(8'h04, 8'h05);
        rd(8'h07, 8'h00);
        chk("pin mode", 8'h00, {7'h00, sub_pins_osc_mode_q});
        rate("wdt ticks", 2, 26, 31);
        wr(8'h02, 8'h02);
        settle;
        chk("ls locked", 8'h01, {7'h00, ls_osc_en_q});
        wr(8'h02, 8'h00);
        ls_osc_stoppable <= 1'b1;
        wr(8'h02, 8'h02);
        settle;
        chk("ls stopped", 8'h00, {7'h00, ls_osc_en_q});
        rate("wdt idle", 2, 0, 0);
        rate("tmr idle", 3, 0, 0);
        wr(8'h02, 8'h00);
        settle;
        chk("ls restarted", 8'h01, {7'h00, ls_osc_en_q});
        @(posedge clk);
        wdt_enable <= 1'b0;
        rate("wdt off", 2, 0, 0);
        rate("tmr on", 3, 26, 31);
        wr(8'h04, 8'h03);
        rd(8'h04, 8'h03);
        wr(8'h03, 8'h10);
        settle;
        chk("sub osc", 8'h03, {6'h00, sub_osc_en_q, sub_pins_osc_mode_q});
        rd(8'h03, 8'h10);
        // every legal divider code gives the subsystem clock over two
        for (k = 0; k < 5; k++) begin
            wr(8'h00, 8'h10 | k[7:0]);
            poll(8'h00, 5, 1'b1);
            rd(8'h00, 8'h30 | k[7:0]);
            rate("cpu on sub", 0, 18, 22);
        end
        wr(8'h00, 8'h17);
        rd(8'h00, 8'h34);
        rd(8'h01, 8'h00);
        @(posedge clk);
        stop_mode <= 1'b1;
        settle;
        chk("stop enables", 8'h01, {6'h00, hs_osc_en_q, sub_osc_en_q});
        @(posedge clk);
        stop_mode <= 1'b0;
        wr(8'h00, 8'h01);
        poll(8'h00, 5, 1'b0);
        rate("cpu on hs", 0, 48, 52);
        rate("periph on hs", 1, 98, 101);
        wr(8'h03, 8'h50);
        wr(8'h01, 8'h05);
        poll(8'h01, 1, 1'b1);
        rd(8'h01, 8'h07);
        chk("main enables", 8'h02, {6'h00, main_xtal_en_q, ext_clk_en_q});
        rate("cpu on x1", 0, 31, 35);
        rate("periph on x1", 1, 64, 69);
        wr(8'h03, 8'hD0);
        rate("periph on ext", 1, 45, 52);
        rate("cpu on ext", 0, 22, 27);
        chk("ext enables", 8'h01, {6'h00, main_xtal_en_q, ext_clk_en_q});
        wr(8'h02, 8'h01);
        settle;
        chk("hs stopped", 8'h00, {7'h00, hs_osc_en_q});
        rd(8'h02, 8'h01);
        rate("periph after hs stop", 1, 45, 52);
        poll(8'h00, 5, 1'b0);
        wr(8'h03, 8'hC0);
        settle;
        chk("sub off", 8'h00, {6'h00, sub_osc_en_q, sub_pins_osc_mode_q});
        results();
    end
endmodule // testbench
